// ### core/seq_pkg.sv
// Shared constants and types of the colour feedback mode sequencer
package seq_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int SCL_HZ = 100_000;
  localparam int QTR_CYCLES = CLK_HZ / (4 * SCL_HZ);
  localparam logic [6:0] STORE_DEV_ADDR = 7'h50;
  localparam int REG_WORDS = 64;
  localparam int DUTY_W = 12;
  localparam logic [DUTY_W-1:0] DUTY_MAX = 12'hFFF;
  localparam logic [DUTY_W-1:0] DUTY_RESET = 12'h000;
  localparam int WRITE_WAIT_US = 5000;
  localparam int WRITE_WAIT_CYCLES = WRITE_WAIT_US * CLK_MHZ;
  localparam int SAMPLE_HZ = 108;
  localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
  typedef enum logic [3:0] {
    CMD_NONE,
    CMD_LOAD_DONE,
    CMD_UPLOAD,
    CMD_DOWNLOAD,
    CMD_OPEN_LOOP,
    CMD_CLOSED_LOOP,
    CMD_SEARCH,
    CMD_SAMPLE_RED,
    CMD_SAMPLE_GREEN,
    CMD_SAMPLE_BLUE,
    CMD_CALC
  } cmd_e;
  typedef enum logic [1:0] {COL_RED, COL_GREEN, COL_BLUE} colour_e;
  typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} link_op_e;
endpackage

// ### core/store_if.sv
// Byte operation channel between sequencer and store link
`timescale 1ns/10ps
interface store_if;
  import seq_pkg::*;
  logic start;
  link_op_e op;
  logic [7:0] wdata;
  logic ack_out;
  logic done;
  logic [7:0] rdata;
  logic ack_in;
  modport ctrl (output start, op, wdata, ack_out, input done, rdata, ack_in);
  modport eng (input start, op, wdata, ack_out, output done, rdata, ack_in);
endinterface

// ### core/reg_store.sv
// Register data memory with a registered read port
`timescale 1ns/10ps
module reg_store
#(
  parameter int WORDS = 64,
  parameter int AW = 6,
  parameter int W = 8
)
(
  input wire logic clk, // Core clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic we, // Write strobe
  input wire logic [AW-1:0] addr, // Word address
  input wire logic [W-1:0] wdata, // Write data
  output logic [W-1:0] rdata // Data of last cycle's address
);
  logic [W-1:0] mem [WORDS];

  always_ff @(posedge clk)
  begin
    if (we)
      mem[addr] <= wdata;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata <= '0;
    else
      rdata <= mem[addr];
  end
endmodule

// ### core/store_link.sv
// Byte level two-wire master for the serial configuration store
`timescale 1ns/10ps
module store_link
#(
  parameter int QTR = seq_pkg::QTR_CYCLES
)
(
  input wire logic clk, // Core clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic en, // Core enable, low while asleep
  store_if.eng lk, // Byte operation port
  output logic scl_o, // Store clock pin
  input wire logic sda_i, // Store data pin level
  output logic sda_o, // Store data drive value
  output logic sda_oe // Store data pulled low while high
);
  import seq_pkg::*;
  localparam logic [8:0] QTR_LAST = 9'(QTR - 1);
  logic busy_reg, busy_next;
  link_op_e op_reg, op_next;
  logic [3:0] bit_reg, bit_next;
  logic [1:0] ph_reg, ph_next;
  logic [8:0] div_reg, div_next;
  logic [7:0] sh_reg, sh_next;
  logic scl_reg, scl_next;
  logic low_reg, low_next;
  logic ack_reg, ack_next;
  logic done_reg, done_next;
  logic is_byte;
  logic last_bit;

  // Each bit is four quarter periods: set data, rise, sample, fall
  always_comb
  begin
    busy_next = busy_reg;
    op_next = op_reg;
    bit_next = bit_reg;
    ph_next = ph_reg;
    div_next = div_reg;
    sh_next = sh_reg;
    scl_next = scl_reg;
    low_next = low_reg;
    ack_next = ack_reg;
    done_next = 1'b0;
    is_byte = (op_reg == OP_WRITE) || (op_reg == OP_READ);
    last_bit = (bit_reg == 4'h8);
    if (!busy_reg)
    begin
      if (lk.start)
      begin
        busy_next = 1'b1;
        op_next = lk.op;
        sh_next = lk.wdata;
        div_next = 9'h000;
        ph_next = 2'h0;
        bit_next = 4'h0;
      end
    end
    else if (div_reg != QTR_LAST)
      div_next = div_reg + 9'h001;
    else
    begin
      div_next = 9'h000;
      ph_next = ph_reg + 2'h1;
      unique case (ph_reg)
        2'h0:
        begin
          if (op_reg == OP_WRITE)
            low_next = !last_bit && !sh_reg[7];
          else if (op_reg == OP_READ)
            low_next = last_bit && lk.ack_out;
          else
            low_next = (op_reg == OP_STOP);
        end
        2'h1: scl_next = 1'b1;
        2'h2:
        begin
          if (!is_byte)
            low_next = (op_reg == OP_START);
          else if (last_bit)
            ack_next = !sda_i;
          else
            sh_next = {sh_reg[6:0], sda_i};
        end
        2'h3:
        begin
          scl_next = (op_reg == OP_STOP);
          if (!is_byte || last_bit)
          begin
            busy_next = 1'b0;
            done_next = 1'b1;
          end
          else
            bit_next = bit_reg + 4'h1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      busy_reg <= 1'b0;
      op_reg <= OP_START;
      bit_reg <= 4'h0;
      ph_reg <= 2'h0;
      div_reg <= 9'h000;
      sh_reg <= 8'h00;
      scl_reg <= 1'b1;
      low_reg <= 1'b0;
      ack_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else if (en)
    begin
      busy_reg <= busy_next;
      op_reg <= op_next;
      bit_reg <= bit_next;
      ph_reg <= ph_next;
      div_reg <= div_next;
      sh_reg <= sh_next;
      scl_reg <= scl_next;
      low_reg <= low_next;
      ack_reg <= ack_next;
      done_reg <= done_next;
    end
  end

  assign scl_o = scl_reg;
  assign sda_o = 1'b0;
  assign sda_oe = low_reg;
  assign lk.done = done_reg;
  assign lk.rdata = sh_reg;
  assign lk.ack_in = ack_reg;
endmodule

// ### core/color_feedback_mode_sequencer.sv
// Mode and configuration sequencer of the colour feedback controller
`timescale 1ns/10ps
module color_feedback_mode_sequencer
#(
  parameter int WRITE_WAIT_CYC = seq_pkg::WRITE_WAIT_CYCLES,
  parameter int SAMPLE_CYC = seq_pkg::SAMPLE_CYCLES,
  parameter int QTR_CYC = seq_pkg::QTR_CYCLES,
  parameter int WORDS = seq_pkg::REG_WORDS,
  parameter int AW = $clog2(WORDS)
)
(
  input wire logic CLK, // Core clock
  input wire logic RESET_N, // Asynchronous reset, active low
  input wire logic SLEEP, // Sleep request
  input wire logic STANDALONE, // Strap: load from store at start
  input wire logic HOST_WE, // Register write strobe
  input wire logic HOST_RE, // Register read strobe
  input wire logic [AW-1:0] HOST_ADDR, // Register index
  input wire logic [7:0] HOST_WDATA, // Register write data
  output logic HOST_READY, // Host access and command accepted
  output logic [7:0] HOST_RDATA, // Register read data
  output logic HOST_RVALID, // Read data valid pulse
  input wire logic HOST_CMD_VALID, // Command strobe
  input wire seq_pkg::cmd_e HOST_CMD, // Command code
  output logic BUSY, // Sequence in progress
  output logic LOADED, // Register data complete
  output logic OPEN_LOOP, // Feedback disabled
  output logic STORE_ERROR, // Store did not acknowledge
  output logic STORE_SCL, // Store clock
  input wire logic STORE_SDA_I, // Store data level
  output logic STORE_SDA_O, // Store data drive value
  output logic STORE_SDA_OE, // Store data driven
  output logic SAMPLE_REQ, // Sensor conversion request pulse
  input wire logic SENSE_VALID, // Sensor result ready pulse
  input wire logic [2:0] SENSE_HIGH, // Channel brighter than target
  input wire logic [2:0] SENSE_LOW, // Channel dimmer than target
  output logic CAL_STORE, // Store sensor result pulse
  output seq_pkg::colour_e CAL_COLOUR, // Colour of stored result
  output logic SEARCH_START, // Sensitivity search start pulse
  input wire logic SEARCH_DONE, // Sensitivity search finished
  output logic CALC_START, // Matrix calculator start pulse
  input wire logic CALC_DONE, // Matrix calculator finished
  output logic ANALOG_PD, // Analog power down
  output logic RED_DUTY_OUT, // Red PWM
  output logic GREEN_DUTY_OUT, // Green PWM
  output logic BLUE_DUTY_OUT // Blue PWM
);
  import seq_pkg::*;
  typedef enum logic [4:0] {
    S_BOOT, S_WAIT, S_NORMAL, S_SEARCH, S_CALC,
    S_UP_BEGIN, S_UP_DEV, S_UP_ADDR, S_UP_DATA, S_UP_END, S_UP_GAP,
    S_DN_BEGIN, S_DN_DEVW, S_DN_ADDR, S_DN_RESTART, S_DN_DEVR,
    S_DN_DATA, S_DN_END
  } state_e;
  localparam logic [AW-1:0] LAST_IDX = AW'(WORDS - 1);

  function automatic logic is_link(input state_e s);
    return (s >= S_UP_BEGIN);
  endfunction

  function automatic logic [DUTY_W-1:0] step(input logic [DUTY_W-1:0] d,
                                             input logic hi, input logic lo);
    if (hi && !lo && d != DUTY_RESET)
      return d - 1'b1;
    if (lo && !hi && d != DUTY_MAX)
      return d + 1'b1;
    return d;
  endfunction

  state_e state_reg, state_next;
  logic [AW-1:0] idx_reg, idx_next;
  logic [31:0] cnt_reg, cnt_next;
  logic loaded_reg, loaded_next;
  logic open_reg, open_next;
  logic err_reg, err_next;
  logic fail_reg, fail_next;
  logic issued_reg, issued_next;
  logic pend_reg, pend_next;
  colour_e colour_reg, colour_next;
  logic sample_reg, sample_next;
  logic store_reg, store_next;
  logic search_reg, search_next;
  logic calc_reg, calc_next;
  logic rvalid_reg, rvalid_next;
  logic pd_reg;
  logic [DUTY_W-1:0] duty_reg [3];
  logic [DUTY_W-1:0] duty_next [3];
  logic [DUTY_W-1:0] pwm_reg, pwm_next;
  logic [2:0] out_reg, out_next;
  logic en, take, fb_on, pwm_on, step_done, nack;
  logic mem_we;
  logic [AW-1:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata;
  store_if lk ();

  assign en = !SLEEP;
  assign HOST_READY = en && !pend_reg &&
                      (state_reg == S_WAIT || state_reg == S_NORMAL);
  assign take = HOST_CMD_VALID && HOST_READY;
  assign fb_on = state_reg == S_NORMAL && loaded_reg && !open_reg &&
                 !pend_reg;
  assign pwm_on = loaded_reg || state_reg == S_SEARCH;
  assign step_done = issued_reg && lk.done;
  assign nack = step_done && lk.op == OP_WRITE && !lk.ack_in;

  always_comb
  begin
    state_next = state_reg;
    idx_next = idx_reg;
    cnt_next = cnt_reg;
    loaded_next = loaded_reg;
    open_next = open_reg;
    err_next = err_reg;
    fail_next = fail_reg;
    issued_next = issued_reg;
    pend_next = pend_reg;
    colour_next = colour_reg;
    sample_next = 1'b0;
    store_next = 1'b0;
    search_next = 1'b0;
    calc_next = 1'b0;
    rvalid_next = HOST_RE && HOST_READY;
    duty_next = duty_reg;
    pwm_next = pwm_reg + 1'b1;
    for (int i = 0; i < 3; i++)
      out_next[i] = pwm_on && (pwm_reg < duty_reg[i]);
    lk.start = is_link(state_reg) && state_reg != S_UP_GAP && !issued_reg;
    lk.op = OP_WRITE;
    lk.wdata = 8'h00;
    lk.ack_out = 1'b0;
    mem_we = HOST_WE && HOST_READY;
    mem_addr = is_link(state_reg) ? idx_reg : HOST_ADDR;
    mem_wdata = HOST_WDATA;
    if (lk.start)
      issued_next = 1'b1;
    if (step_done)
      issued_next = 1'b0;
    if (pend_reg && SENSE_VALID)
    begin
      store_next = 1'b1;
      pend_next = 1'b0;
    end
    unique case (state_reg)
      S_BOOT: state_next = STANDALONE ? S_DN_BEGIN : S_WAIT;
      S_WAIT, S_NORMAL:
      begin
        if (fb_on)
        begin
          if (cnt_reg == 32'(SAMPLE_CYC - 1))
          begin
            cnt_next = 32'h0;
            sample_next = 1'b1;
          end
          else
            cnt_next = cnt_reg + 32'h1;
          if (SENSE_VALID)
            for (int i = 0; i < 3; i++)
              duty_next[i] = step(duty_reg[i], SENSE_HIGH[i],
                                  SENSE_LOW[i]);
        end
        if (take)
        begin
          unique case (HOST_CMD)
            CMD_LOAD_DONE:
            begin
              loaded_next = 1'b1;
              state_next = S_NORMAL;
            end
            CMD_UPLOAD:
            begin
              idx_next = '0;
              fail_next = 1'b0;
              err_next = 1'b0;
              state_next = S_UP_BEGIN;
            end
            CMD_DOWNLOAD:
            begin
              idx_next = '0;
              fail_next = 1'b0;
              err_next = 1'b0;
              state_next = S_DN_BEGIN;
            end
            CMD_OPEN_LOOP: open_next = 1'b1;
            CMD_CLOSED_LOOP: open_next = 1'b0;
            CMD_SEARCH:
            begin
              for (int i = 0; i < 3; i++)
                duty_next[i] = DUTY_MAX;
              search_next = 1'b1;
              state_next = S_SEARCH;
            end
            CMD_SAMPLE_RED, CMD_SAMPLE_GREEN, CMD_SAMPLE_BLUE:
            begin
              sample_next = 1'b1;
              pend_next = 1'b1;
              if (HOST_CMD == CMD_SAMPLE_RED)
                colour_next = COL_RED;
              else if (HOST_CMD == CMD_SAMPLE_GREEN)
                colour_next = COL_GREEN;
              else
                colour_next = COL_BLUE;
            end
            CMD_CALC:
            begin
              calc_next = 1'b1;
              state_next = S_CALC;
            end
            default: ;
          endcase
        end
      end
      S_SEARCH:
        if (SEARCH_DONE)
          state_next = loaded_reg ? S_NORMAL : S_WAIT;
      S_CALC:
        if (CALC_DONE)
          state_next = loaded_reg ? S_NORMAL : S_WAIT;
      S_UP_BEGIN, S_DN_BEGIN, S_DN_RESTART:
      begin
        lk.op = OP_START;
        if (step_done)
          state_next = state_e'(state_reg + 1'b1);
      end
      S_UP_DEV, S_DN_DEVW, S_DN_DEVR, S_UP_ADDR, S_DN_ADDR, S_UP_DATA:
      begin
        if (state_reg == S_DN_DEVR)
          lk.wdata = {STORE_DEV_ADDR, 1'b1};
        else if (state_reg == S_UP_ADDR)
          lk.wdata = 8'(idx_reg);
        else if (state_reg == S_UP_DATA)
          lk.wdata = mem_rdata;
        else if (state_reg != S_DN_ADDR)
          lk.wdata = {STORE_DEV_ADDR, 1'b0};
        if (nack)
        begin
          err_next = 1'b1;
          fail_next = 1'b1;
          state_next = state_reg < S_DN_BEGIN ? S_UP_END : S_DN_END;
        end
        else if (step_done)
          state_next = state_e'(state_reg + 1'b1);
      end
      S_DN_DATA:
      begin
        lk.op = OP_READ;
        lk.ack_out = idx_reg != LAST_IDX;
        if (step_done)
        begin
          mem_we = 1'b1;
          mem_wdata = lk.rdata;
          if (idx_reg == LAST_IDX)
            state_next = S_DN_END;
          else
            idx_next = idx_reg + 1'b1;
        end
      end
      S_UP_END:
      begin
        lk.op = OP_STOP;
        cnt_next = 32'h0;
        if (step_done)
          state_next = fail_reg ? (loaded_reg ? S_NORMAL : S_WAIT) : S_UP_GAP;
      end
      S_UP_GAP:
      begin
        cnt_next = cnt_reg + 32'h1;
        if (cnt_reg == 32'(WRITE_WAIT_CYC - 1))
        begin
          cnt_next = 32'h0;
          if (idx_reg == LAST_IDX)
            state_next = loaded_reg ? S_NORMAL : S_WAIT;
          else
          begin
            idx_next = idx_reg + 1'b1;
            state_next = S_UP_BEGIN;
          end
        end
      end
      S_DN_END:
      begin
        lk.op = OP_STOP;
        if (step_done)
        begin
          loaded_next = loaded_reg || !fail_reg;
          open_next = open_reg && fail_reg;
          state_next = (loaded_reg || !fail_reg) ? S_NORMAL : S_WAIT;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state_reg <= S_BOOT;
      idx_reg <= '0;
      cnt_reg <= 32'h0;
      loaded_reg <= 1'b0;
      open_reg <= 1'b0;
      err_reg <= 1'b0;
      fail_reg <= 1'b0;
      issued_reg <= 1'b0;
      pend_reg <= 1'b0;
      colour_reg <= COL_RED;
      pwm_reg <= DUTY_RESET;
      out_reg <= 3'h0;
      for (int i = 0; i < 3; i++)
        duty_reg[i] <= DUTY_RESET;
    end
    else if (en)
    begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      cnt_reg <= cnt_next;
      loaded_reg <= loaded_next;
      open_reg <= open_next;
      err_reg <= err_next;
      fail_reg <= fail_next;
      issued_reg <= issued_next;
      pend_reg <= pend_next;
      colour_reg <= colour_next;
      pwm_reg <= pwm_next;
      out_reg <= out_next;
      duty_reg <= duty_next;
    end
  end

  // Pulses are cleared in sleep so none repeats across it
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      sample_reg <= 1'b0;
      store_reg <= 1'b0;
      search_reg <= 1'b0;
      calc_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      pd_reg <= 1'b0;
    end
    else
    begin
      sample_reg <= en && sample_next;
      store_reg <= en && store_next;
      search_reg <= en && search_next;
      calc_reg <= en && calc_next;
      rvalid_reg <= en && rvalid_next;
      pd_reg <= SLEEP;
    end
  end

  reg_store #(.WORDS(WORDS), .AW(AW), .W(8)) u_mem (
    .clk(CLK),
    .reset_n(RESET_N),
    .we(mem_we && en),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  store_link #(.QTR(QTR_CYC)) u_link (
    .clk(CLK),
    .reset_n(RESET_N),
    .en(en),
    .lk(lk.eng),
    .scl_o(STORE_SCL),
    .sda_i(STORE_SDA_I),
    .sda_o(STORE_SDA_O),
    .sda_oe(STORE_SDA_OE)
  );

  assign HOST_RDATA = mem_rdata;
  assign HOST_RVALID = rvalid_reg;
  assign BUSY = !(state_reg == S_WAIT || state_reg == S_NORMAL);
  assign LOADED = loaded_reg;
  assign OPEN_LOOP = open_reg;
  assign STORE_ERROR = err_reg;
  assign SAMPLE_REQ = sample_reg;
  assign CAL_STORE = store_reg;
  assign CAL_COLOUR = colour_reg;
  assign SEARCH_START = search_reg;
  assign CALC_START = calc_reg;
  assign ANALOG_PD = pd_reg;
  assign RED_DUTY_OUT = out_reg[0];
  assign GREEN_DUTY_OUT = out_reg[1];
  assign BLUE_DUTY_OUT = out_reg[2];

  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  sequence s_take(cmd_e c);
    take && HOST_CMD == c;
  endsequence
  sequence s_started(state_e s);
    state_reg == s && lk.start ##1 (issued_reg || $past(SLEEP));
  endsequence

  property p_dark;
    !pwm_on && !SLEEP |=> !RED_DUTY_OUT && !GREEN_DUTY_OUT && !BLUE_DUTY_OUT;
  endproperty
  a_dark: assert property (p_dark)
    else $error("PWM active before register data complete");
  property p_down;
    fb_on && SENSE_VALID && SENSE_HIGH[0] && !SENSE_LOW[0] && !SLEEP &&
      duty_reg[0] != DUTY_RESET && !take
      |=> duty_reg[0] == $past(duty_reg[0]) - 1'b1;
  endproperty
  a_down: assert property (p_down)
    else $error("Red duty not lowered on bright error");
  property p_open;
    open_reg && state_reg == S_NORMAL && !take |=> $stable(duty_reg[1]);
  endproperty
  a_open: assert property (p_open)
    else $error("Duty corrected in open loop");
  property p_search;
    s_take(CMD_SEARCH) |=> SEARCH_START && duty_reg[2] == DUTY_MAX;
  endproperty
  a_search: assert property (p_search)
    else $error("Search did not start at full duty");
  property p_calc;
    s_take(CMD_CALC) |=> CALC_START && state_reg == S_CALC ##1 !CALC_START;
  endproperty
  a_calc: assert property (p_calc)
    else $error("Calculator start not a single pulse");
  property p_store;
    pend_reg && SENSE_VALID && !SLEEP |=> CAL_STORE && !pend_reg;
  endproperty
  a_store: assert property (p_store)
    else $error("Sensor result not stored");
  property p_dev;
    lk.start && state_reg == S_DN_DEVR |-> lk.wdata == 8'hA1;
  endproperty
  a_dev: assert property (p_dev)
    else $error("Wrong store device address");
  property p_upload;
    s_take(CMD_UPLOAD) |=> idx_reg == '0 ##0 s_started(S_UP_BEGIN);
  endproperty
  a_upload: assert property (p_upload)
    else $error("Upload did not begin");
  property p_load;
    s_take(CMD_LOAD_DONE) |=> loaded_reg && state_reg == S_NORMAL;
  endproperty
  a_load: assert property (p_load)
    else $error("Load completion did not enter normal mode");
  property p_dn_end;
    state_reg == S_DN_END && step_done && !fail_reg && !SLEEP
      |=> loaded_reg && state_reg == S_NORMAL && !open_reg;
  endproperty
  a_dn_end: assert property (p_dn_end)
    else $error("Download did not end in normal mode");
  property p_boot;
    state_reg == S_BOOT && STANDALONE && !SLEEP |=> s_started(S_DN_BEGIN);
  endproperty
  a_boot: assert property (p_boot)
    else $error("Standalone start did not download");
  property p_read;
    HOST_RE && HOST_READY |=> HOST_RVALID ##1
      (!HOST_RVALID || $past(HOST_RE && HOST_READY));
  endproperty
  a_read: assert property (p_read)
    else $error("Read back not answered");
  property p_sleep;
    SLEEP |-> !HOST_READY ##1 $stable(state_reg) && ANALOG_PD;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("Core not frozen in sleep");
endmodule

// ### tb/store_model.sv
// Serial configuration store model on the two-wire link
`timescale 1ns/10ps
module store_model
(
  input wire logic scl, // Link clock
  input wire logic sda, // Resolved data line, pulled up
  output logic drv // Pulls the data line low
);
  logic [7:0] mem [2];
  logic [7:0] sh = 8'h00;
  logic [7:0] ptr = 8'h00;
  logic rd = 1'b0;
  int c = 0;
  int b = 0;
  initial drv = 1'b0;
  // Start condition restarts the frame
  always @(negedge sda)
    if (scl)
    begin
      c = 0;
      b = 0;
    end
  always @(posedge scl)
  begin
    if (c < 8)
      sh = {sh[6:0], sda};
    c = c + 1;
    if (c == 9)
    begin
      c = 0;
      if (b == 0)
        rd = sh[0];
      else if (rd || b > 1)
        ptr = ptr + 8'h01;
      else
        ptr = sh;
      if (!rd && b > 1)
        mem[ptr[0] ^ 1'b1] = sh;
      b = b + 1;
      // A refused byte ends the read and frees the line
      if (rd && sda)
        rd = 1'b0;
    end
  end
  // Acknowledge only the fixed device address and written bytes
  always @(negedge scl)
    if (c == 8)
      drv = (b == 0) ? sh[7:1] == 7'h50 : !rd;
    else
      drv = rd && b > 0 && !mem[ptr[0]][7-c];
endmodule

// ### tb/tb.sv
// Self-checking bench of the colour feedback mode sequencer
`timescale 1ns/10ps
module tb;
  import seq_pkg::*;
  logic CLK = 0, RESET_N = 0, SLEEP = 0, STANDALONE = 0, drv;
  logic HOST_WE = 0, HOST_RE = 0, HOST_CMD_VALID = 0, SENSE_VALID = 0;
  logic SEARCH_DONE = 0, CALC_DONE = 0, HOST_READY, HOST_RVALID, BUSY;
  logic [0:0] HOST_ADDR = 1'b0;
  logic [7:0] HOST_WDATA = 8'h00, HOST_RDATA, exp [2];
  logic [2:0] SENSE_HIGH = 3'h0, SENSE_LOW = 3'h0;
  cmd_e HOST_CMD = CMD_NONE;
  colour_e CAL_COLOUR;
  logic LOADED, OPEN_LOOP, STORE_ERROR, STORE_SCL, STORE_SDA_O, STORE_SDA_OE;
  logic SAMPLE_REQ, CAL_STORE, SEARCH_START, CALC_START, ANALOG_PD;
  logic RED_DUTY_OUT, GREEN_DUTY_OUT, BLUE_DUTY_OUT;
  int errors = 0, n_compared = 0, i, n;
  wire sda_w = !drv && (!STORE_SDA_OE || STORE_SDA_O);
  always #5 CLK = ~CLK;
  color_feedback_mode_sequencer #(.WRITE_WAIT_CYC(20), .SAMPLE_CYC(50),
    .WORDS(2), .QTR_CYC(25)) color_feedback_mode_sequencer_inst (.*,
    .STORE_SDA_I(sda_w));
  store_model store_model_inst (.scl(STORE_SCL), .sda(sda_w), .drv(drv));
  task chk(input string s, input logic [11:0] e, input logic [11:0] g);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task tick(input int k);
    repeat (k) @(negedge CLK);
  endtask
  task automatic wt(ref logic s, input logic v, input int m);
    int j;
    for (j = 0; j < m && s !== v; j++)
      tick(1);
    if (j >= m)
    begin
      errors++;
      $display("Error wait expected %b seen timeout", v);
      print_verdict;
    end
  endtask
  // Request held until the edge that samples ready high
  task automatic hold(ref logic s);
    tick(1);
    s = 1'b1;
    wt(HOST_READY, 1'b1, 99);
    tick(1);
    s = 1'b0;
  endtask
  task cmd(input cmd_e c);
    HOST_CMD = c;
    hold(HOST_CMD_VALID);
  endtask
  task sense(input logic [2:0] h, input logic [2:0] l);
    SENSE_HIGH = h;
    SENSE_LOW = l;
    SENSE_VALID = 1'b1;
    tick(1);
    SENSE_VALID = 1'b0;
  endtask
  task pw(input int r, input int g, input int b);
    int cr, cg, cb;
    cr = 0;
    cg = 0;
    cb = 0;
    repeat (4096)
    begin
      tick(1);
      cr += RED_DUTY_OUT;
      cg += GREEN_DUTY_OUT;
      cb += BLUE_DUTY_OUT;
    end
    chk("red duty", r, cr);
    chk("green duty", g, cg);
    chk("blue duty", b, cb);
  endtask
  task rdall;
    for (i = 0; i < 2; i++)
    begin
      HOST_ADDR = i[0];
      hold(HOST_RE);
      chk("rvalid", 1, HOST_RVALID);
      chk("rdata", exp[i], HOST_RDATA);
    end
  endtask
  initial
  begin
    i = $urandom(74);
    tick(2);
    RESET_N = 1'b1;
    tick(2);
    chk("loaded", 0, LOADED);
    chk("red out", 0, RED_DUTY_OUT);
    for (i = 0; i < 2; i++)
    begin
      exp[i] = 8'($urandom);
      HOST_ADDR = i[0];
      HOST_WDATA = exp[i];
      hold(HOST_WE);
    end
    rdall;
    cmd(CMD_LOAD_DONE);
    chk("loaded", 1, LOADED);
    n = $urandom_range(4, 1);
    repeat (n)
    begin
      wt(SAMPLE_REQ, 1'b1, 120);
      sense(3'b010, 3'b001);
    end
    wt(SAMPLE_REQ, 1'b1, 120);
    sense(3'b001, 3'b000);
    pw(n - 1, 0, 0);
    $display("test feedback done");
    cmd(CMD_OPEN_LOOP);
    chk("open", 1, OPEN_LOOP);
    n = 0;
    repeat (120)
    begin
      tick(1);
      n += SAMPLE_REQ;
    end
    chk("requests", 0, n);
    for (i = 0; i < 3; i++)
    begin
      cmd(cmd_e'(7 + i));
      wt(SAMPLE_REQ, 1'b1, 9);
      sense(3'b000, 3'b000);
      chk("store", 1, CAL_STORE);
      chk("colour", i, CAL_COLOUR);
    end
    cmd(CMD_SEARCH);
    wt(SEARCH_START, 1'b1, 9);
    pw(4095, 4095, 4095);
    chk("busy", 1, BUSY);
    SEARCH_DONE = 1'b1;
    wt(BUSY, 1'b0, 9);
    SEARCH_DONE = 1'b0;
    cmd(CMD_CALC);
    wt(CALC_START, 1'b1, 9);
    tick(3);
    chk("busy", 1, BUSY);
    CALC_DONE = 1'b1;
    wt(BUSY, 1'b0, 9);
    CALC_DONE = 1'b0;
    cmd(CMD_CLOSED_LOOP);
    chk("open", 0, OPEN_LOOP);
    $display("test calibration done");
    SLEEP = 1'b1;
    tick(1);
    chk("power down", 1, ANALOG_PD);
    chk("ready", 0, HOST_READY);
    SLEEP = 1'b0;
    cmd(CMD_UPLOAD);
    chk("busy", 1, BUSY);
    wt(BUSY, 1'b0, 100000);
    chk("store error", 0, STORE_ERROR);
    for (i = 0; i < 2; i++)
      chk("stored", exp[i], store_model_inst.mem[i]);
    chk("sda value", 0, STORE_SDA_O);
    HOST_ADDR = 1'b0;
    HOST_WDATA = ~exp[0];
    hold(HOST_WE);
    cmd(CMD_DOWNLOAD);
    wt(BUSY, 1'b0, 100000);
    chk("store error", 0, STORE_ERROR);
    rdall;
    RESET_N = 1'b0;
    STANDALONE = 1'b1;
    tick(2);
    RESET_N = 1'b1;
    wt(LOADED, 1'b1, 60000);
    chk("open", 0, OPEN_LOOP);
    rdall;
    $display("test store done");
    print_verdict;
  end
endmodule
